// *** include/tap_pkg.sv ***
// Purpose: shared constants, types and decoders for the test access port
// Assumes: three-bit instruction register, 196-cell boundary register
// Notes: identification fields are parameters of the top module
package tap_pkg;

   // instruction register size and codes
   localparam int IR_LEN = 3;
   localparam logic [2:0] IR_EXTEST = 3'h0;
   localparam logic [2:0] IR_IDCODE = 3'h1;
   localparam logic [2:0] IR_SAMPLE = 3'h2;
   localparam logic [2:0] IR_CLAMP = 3'h3;
   localparam logic [2:0] IR_HIGHZ = 3'h4;
   localparam logic [2:0] IR_BYPASS = 3'h7;
   // fixed pattern loaded in capture-ir; low two bits must read 01
   localparam logic [2:0] IR_CAPTURE = 3'h1;
   // instruction held after test reset
   localparam logic [2:0] IR_RESET = IR_IDCODE;

   // boundary register length and its global output-enable cell
   localparam int BSR_LEN = 196;
   localparam int BSR_OUT_ENB_BIT = 0;

   // identification register layout
   localparam int ID_LEN = 32;
   localparam int ID_MAKER_W = 11;
   localparam int ID_PART_W = 16;
   localparam int ID_VER_W = 4;
   localparam logic ID_MARKER = 1'b1;

   // tms-high edges that always reach test-logic-reset
   localparam int TMS_RESET_EDGES = 5;

   // controller states
   typedef enum logic [3:0] {
      st_reset, st_idle,
      st_sel_dr, st_capture_dr, st_shift_dr, st_exit1_dr,
      st_pause_dr, st_exit2_dr, st_update_dr,
      st_sel_ir, st_capture_ir, st_shift_ir, st_exit1_ir,
      st_pause_ir, st_exit2_ir, st_update_ir
   } tap_state_t;

   // data register chosen by the current instruction
   typedef enum logic [1:0] {
      sel_boundary, sel_bypass, sel_ident
   } dr_sel_t;

   // pin control word handed from the test clock to the system clock
   typedef struct packed {
      logic drive;
      logic highz;
      logic [BSR_LEN-1:0] cells;
   } pin_ctrl_t;

   // which data register sits in the scan path
   function automatic dr_sel_t decode_sel(input logic [2:0] code);
      dr_sel_t sel;
      sel = sel_bypass;
      case (code)
         IR_EXTEST, IR_SAMPLE: sel = sel_boundary;
         IR_IDCODE: sel = sel_ident;
         default: sel = sel_bypass;
      endcase
      return sel;
   endfunction

   // pins driven from the boundary latches
   function automatic logic decode_drive(input logic [2:0] code);
      return (code == IR_EXTEST) || (code == IR_CLAMP);
   endfunction

endpackage

// *** rtl/tap_boundary_reg.sv ***
// Purpose: boundary scan register, shift stages plus update latches
// Assumes: runs on the test clock; enables come from the controller
// Notes: shifts toward bit 0, which is the serial output
`timescale 1ns/1ps
module tap_boundary_reg #(
   parameter int LEN = 196
) (
   // test clock and asynchronous test reset
   input wire logic i_tck,
   input wire logic i_trst_n,
   // controller strobes; capture and update last one test clock, shift stays high through shift-dr
   input wire logic i_capture,
   input wire logic i_shift,
   input wire logic i_update,
   // serial and parallel data
   input wire logic i_serial_in,
   input wire logic [LEN-1:0] i_parallel_in,
   output logic o_serial_out,
   output logic [LEN-1:0] o_cells
);

   logic [LEN-1:0] stage;

   generate
      if (LEN < 2)
      begin : g_bad
         $error("boundary register needs at least two cells");
      end
   endgenerate

   // one shift cell per pin or control bit
   genvar c;
   generate
      for (c = 0; c < LEN; c++)
      begin : g_cell
         logic from_up;
         assign from_up = (c == LEN - 1) ? i_serial_in : stage[(c + 1) % LEN];
         always_ff @(posedge i_tck or negedge i_trst_n)
         begin
            if (!i_trst_n)
               stage[c] <= 1'b0;
            else if (i_capture)
               stage[c] <= i_parallel_in[c];
            else if (i_shift)
               stage[c] <= from_up;
         end
      end
   endgenerate

   assign o_serial_out = stage[0];

   // latches move on the falling edge so the pins never see shifting
   always_ff @(negedge i_tck or negedge i_trst_n)
   begin
      if (!i_trst_n)
         o_cells <= '0;
      else if (i_update)
         o_cells <= stage;
   end

   // each shift moves the chain one stage from serial in toward bit 0
   cell_shift_a: assert property (@(posedge i_tck) disable iff (!i_trst_n)
      i_shift && !i_capture |=> stage[LEN-1] == $past(i_serial_in)
         && stage[0] == $past(stage[1]))
      else $error("boundary chain did not advance one stage");

endmodule

// *** rtl/boundary_scan_tap.sv ***
// Purpose: test access port with controller, instruction and data registers
// Assumes: test clock 30 ns bench period, unrelated to 250 MHz i_clk
// Notes: pin muxing runs on i_clk, control word crosses by toggle handshake
//
// How it works
// - controller moves on rising test clock, steered by mode select; test reset forces it at once
// - after reset: test-logic-reset, idcode current; system pins normal, or left on the last word if test reset finds the toggle low
// - select-dr goes capture-dr on low, select-ir on high; registers hold
// - capture-dr loads selected register if loadable; then shift or exit1
// - shift-dr moves selected register one stage per edge; others hold
// - exit1-dr goes update-dr on high, pause-dr on low
// - pause-dr holds while low, exit2-dr on high; exit2 to update or shift
// - update-dr copies shift path to latches on falling clock
// - select-ir goes capture-ir on low, test-logic-reset on high
// - capture-ir loads fixed value; then exit1-ir on high, shift-ir on low
// - shift-ir moves instruction shifter per edge; parallel parts hold
// - exit1-ir, pause-ir, exit2-ir follow the usual low/high branches
// - falling clock on entering update-ir makes the shifted code current
// - three-bit instruction: 010 sample, 111 bypass, 000 extest
// - 011 clamp and 100 high-z use bypass; 001 idcode uses id register
// - sample captures pins without disturbing them; shift preloads
// - extest drives outputs from boundary latches and captures inputs
// - bypass passes serial data through one bit, device runs normally
// - idcode loads id in capture-dr, shifts it out; reset selects idcode
// - id code: lsb one, 11 maker bits, 16 part bits, 4 version bits
// - high-z floats every output while bypass forms the path
// - clamp drives outputs from latches, steady, with bypass in the path
// - boundary register has 196 cells with shift and latch stages
`timescale 1ns/1ps
module boundary_scan_tap
   import tap_pkg::*;
#(
   parameter int NUM_OUT = 16,
   parameter int NUM_IN = 16,
   parameter int OUT_BASE = 1,
   parameter int IN_BASE = 17,
   // arbitrary identification values
   parameter logic [10:0] ID_MAKER = 11'h2AA,
   parameter logic [15:0] ID_PART = 16'h1234,
   parameter logic [3:0] ID_VERSION = 4'h1
) (
   // system clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // test port, test clock domain
   input wire logic i_test_clock_in,
   input wire logic i_test_reset_in_n,
   input wire logic i_test_mode_select,
   input wire logic i_test_serial_in,
   output logic o_test_serial_out,
   output logic o_test_serial_out_oe_n,
   // core side of the pins
   input wire logic [NUM_OUT-1:0] i_core_out,
   input wire logic [NUM_OUT-1:0] i_core_oe_n,
   input wire logic [NUM_IN-1:0] i_pin_in,
   // pad side of the outputs
   output logic [NUM_OUT-1:0] o_pin_out,
   output logic [NUM_OUT-1:0] o_pin_oe_n
);

   import tap_pkg::*;

   localparam int SAMP_W = 1 + NUM_OUT + NUM_IN;

   generate
      if (OUT_BASE < 1 || OUT_BASE + NUM_OUT > IN_BASE
         || IN_BASE + NUM_IN > BSR_LEN)
      begin : g_bad_map
         $error("pin cells do not fit the boundary register");
      end
      if (ID_MAKER_W + ID_PART_W + ID_VER_W + 1 != ID_LEN)
      begin : g_bad_id
         $error("identification fields do not fill the register");
      end
   endgenerate

   // test clock domain state
   tap_state_t state;
   tap_state_t next_state;
   logic [IR_LEN-1:0] ir_shift;
   logic [IR_LEN-1:0] ir;
   logic bypass;
   logic [ID_LEN-1:0] id_shift;
   logic [ID_LEN-1:0] id_code;
   dr_sel_t sel;
   logic cap_dr;
   logic sh_dr;
   logic upd_dr;
   logic bsr_out;
   logic [BSR_LEN-1:0] bsr_cells;
   logic [BSR_LEN-1:0] bsr_sample;
   logic [SAMP_W-1:0] samp_meta;
   logic [SAMP_W-1:0] samp_sync;
   pin_ctrl_t ctrl;
   pin_ctrl_t next_ctrl;
   logic ctrl_tgl;

   // system clock domain state
   logic tgl_meta;
   logic tgl_sync;
   logic tgl_seen;
   pin_ctrl_t sys_ctrl;

   assign id_code = {ID_VERSION, ID_PART, ID_MAKER, ID_MARKER};
   assign sel = decode_sel(ir);
   assign cap_dr = (state == st_capture_dr);
   assign sh_dr = (state == st_shift_dr);
   assign upd_dr = (state == st_update_dr);

   // controller next state from mode select
   always_comb
   begin
      next_state = state;
      case (state)
         st_reset: next_state = i_test_mode_select ? st_reset : st_idle;
         st_idle: next_state = i_test_mode_select ? st_sel_dr : st_idle;
         st_sel_dr: next_state = i_test_mode_select ? st_sel_ir
            : st_capture_dr;
         st_capture_dr: next_state = i_test_mode_select ? st_exit1_dr
            : st_shift_dr;
         st_shift_dr: next_state = i_test_mode_select ? st_exit1_dr
            : st_shift_dr;
         st_exit1_dr: next_state = i_test_mode_select ? st_update_dr
            : st_pause_dr;
         st_pause_dr: next_state = i_test_mode_select ? st_exit2_dr
            : st_pause_dr;
         st_exit2_dr: next_state = i_test_mode_select ? st_update_dr
            : st_shift_dr;
         st_update_dr: next_state = i_test_mode_select ? st_sel_dr
            : st_idle;
         st_sel_ir: next_state = i_test_mode_select ? st_reset
            : st_capture_ir;
         st_capture_ir: next_state = i_test_mode_select ? st_exit1_ir
            : st_shift_ir;
         st_shift_ir: next_state = i_test_mode_select ? st_exit1_ir
            : st_shift_ir;
         st_exit1_ir: next_state = i_test_mode_select ? st_update_ir
            : st_pause_ir;
         st_pause_ir: next_state = i_test_mode_select ? st_exit2_ir
            : st_pause_ir;
         st_exit2_ir: next_state = i_test_mode_select ? st_update_ir
            : st_shift_ir;
         st_update_ir: next_state = i_test_mode_select ? st_sel_dr
            : st_idle;
         default: next_state = st_reset;
      endcase
   end

   // controller register; test reset wins at once without a clock
   always_ff @(posedge i_test_clock_in or negedge i_test_reset_in_n)
   begin
      if (!i_test_reset_in_n)
         state <= st_reset;
      else
         state <= next_state;
   end

   // instruction shifter: fixed pattern in capture, shift toward bit 0
   always_ff @(posedge i_test_clock_in or negedge i_test_reset_in_n)
   begin
      if (!i_test_reset_in_n)
         ir_shift <= IR_CAPTURE;
      else if (state == st_capture_ir)
         ir_shift <= IR_CAPTURE;
      else if (state == st_shift_ir)
         ir_shift <= {i_test_serial_in, ir_shift[IR_LEN-1:1]};
   end

   // current instruction, changed only on falling edges
   always_ff @(negedge i_test_clock_in or negedge i_test_reset_in_n)
   begin
      if (!i_test_reset_in_n)
         ir <= IR_RESET;
      else if (state == st_reset)
         ir <= IR_RESET;
      else if (state == st_update_ir)
         ir <= ir_shift;
   end

   // one-bit bypass path, cleared in capture as usual
   always_ff @(posedge i_test_clock_in or negedge i_test_reset_in_n)
   begin
      if (!i_test_reset_in_n)
         bypass <= 1'b0;
      else if (cap_dr && sel == sel_bypass)
         bypass <= 1'b0;
      else if (sh_dr && sel == sel_bypass)
         bypass <= i_test_serial_in;
   end

   // identification shifter; only loaded under idcode
   always_ff @(posedge i_test_clock_in or negedge i_test_reset_in_n)
   begin
      if (!i_test_reset_in_n)
         id_shift <= '0;
      else if (cap_dr && sel == sel_ident)
         id_shift <= id_code;
      else if (sh_dr && sel == sel_ident)
         id_shift <= {i_test_serial_in, id_shift[ID_LEN-1:1]};
   end

   // pin levels come from other clocks, so two flops before capture
   always_ff @(posedge i_test_clock_in or negedge i_test_reset_in_n)
   begin
      if (!i_test_reset_in_n)
      begin
         samp_meta <= '0;
         samp_sync <= '0;
      end
      else
      begin
         samp_meta <= {i_pin_in, o_pin_out, o_pin_oe_n[0]};
         samp_sync <= samp_meta;
      end
   end

   // place synchronised levels on their cells; spare cells capture zero
   always_comb
   begin
      bsr_sample = '0;
      bsr_sample[BSR_OUT_ENB_BIT] = samp_sync[0];
      for (int i = 0; i < NUM_OUT; i++)
         bsr_sample[OUT_BASE + i] = samp_sync[1 + i];
      for (int j = 0; j < NUM_IN; j++)
         bsr_sample[IN_BASE + j] = samp_sync[1 + NUM_OUT + j];
   end

   // boundary register; update only under a boundary instruction, which
   // keeps the latches steady for the whole of clamp
   tap_boundary_reg #(
      .LEN(BSR_LEN)
   ) u_bsr (
      .i_tck(i_test_clock_in),
      .i_trst_n(i_test_reset_in_n),
      .i_capture(cap_dr && sel == sel_boundary),
      .i_shift(sh_dr && sel == sel_boundary),
      .i_update(upd_dr && sel == sel_boundary),
      .i_serial_in(i_test_serial_in),
      .i_parallel_in(bsr_sample),
      .o_serial_out(bsr_out),
      .o_cells(bsr_cells)
   );

   // serial out on the falling edge, floated outside the shift states
   always_ff @(negedge i_test_clock_in or negedge i_test_reset_in_n)
   begin
      if (!i_test_reset_in_n)
      begin
         o_test_serial_out <= 1'b0;
         o_test_serial_out_oe_n <= 1'b1;
      end
      else
      begin
         o_test_serial_out_oe_n <= !(sh_dr || state == st_shift_ir);
         if (state == st_shift_ir)
            o_test_serial_out <= ir_shift[0];
         else if (sh_dr)
         begin
            case (sel)
               sel_boundary: o_test_serial_out <= bsr_out;
               sel_ident: o_test_serial_out <= id_shift[0];
               default: o_test_serial_out <= bypass;
            endcase
         end
      end
   end

   // control word seen by the pins
   always_comb
   begin
      next_ctrl.drive = decode_drive(ir);
      next_ctrl.highz = (ir == IR_HIGHZ);
      next_ctrl.cells = bsr_cells;
   end

   // publish a new word with a toggle; it then stays put for at least
   // one test clock, far longer than the three system clocks to take it
   always_ff @(posedge i_test_clock_in or negedge i_test_reset_in_n)
   begin
      if (!i_test_reset_in_n)
      begin
         ctrl <= '0;
         ctrl_tgl <= 1'b0;
      end
      else if (next_ctrl != ctrl)
      begin
         ctrl <= next_ctrl;
         ctrl_tgl <= !ctrl_tgl;
      end
   end

   // toggle synchroniser into the system clock
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         tgl_meta <= 1'b0;
         tgl_sync <= 1'b0;
         tgl_seen <= 1'b0;
      end
      else
      begin
         tgl_meta <= ctrl_tgl;
         tgl_sync <= tgl_meta;
         tgl_seen <= tgl_sync;
      end
   end

   // take the word once its toggle has settled
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
         sys_ctrl <= '0;
      else if (tgl_sync != tgl_seen)
         sys_ctrl <= ctrl;
   end

   // pin mux: normal path unless a test instruction owns the pins
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_pin_out <= '0;
         o_pin_oe_n <= '1;
      end
      else
      begin
         for (int i = 0; i < NUM_OUT; i++)
         begin
            if (sys_ctrl.highz)
            begin
               o_pin_out[i] <= i_core_out[i];
               o_pin_oe_n[i] <= 1'b1;
            end
            else if (sys_ctrl.drive)
            begin
               o_pin_out[i] <= sys_ctrl.cells[OUT_BASE + i];
               o_pin_oe_n[i] <= sys_ctrl.cells[BSR_OUT_ENB_BIT];
            end
            else
            begin
               o_pin_out[i] <= i_core_out[i];
               o_pin_oe_n[i] <= i_core_oe_n[i];
            end
         end
      end
   end

   // checks in the test clock domain
   sel_dr_step_a: assert property (@(posedge i_test_clock_in)
      disable iff (!i_test_reset_in_n)
      state == st_sel_dr |=> state == ($past(i_test_mode_select)
         ? st_sel_ir : st_capture_dr))
      else $error("select-dr took the wrong branch");

   exit1_dr_a: assert property (@(posedge i_test_clock_in)
      disable iff (!i_test_reset_in_n)
      state == st_exit1_dr && i_test_mode_select |=> state == st_update_dr)
      else $error("exit1-dr did not go to update-dr");

   pause_dr_hold_a: assert property (@(posedge i_test_clock_in)
      disable iff (!i_test_reset_in_n)
      state == st_pause_dr && !i_test_mode_select
         |=> state == st_pause_dr && $stable(bypass) && $stable(id_shift))
      else $error("pause-dr did not hold");

   tms_reset_a: assert property (@(posedge i_test_clock_in)
      disable iff (!i_test_reset_in_n)
      i_test_mode_select [*5] |=> state == st_reset)
      else $error("five high selects did not reach reset");

   capture_ir_a: assert property (@(posedge i_test_clock_in)
      disable iff (!i_test_reset_in_n)
      state == st_capture_ir |=> ir_shift[1:0] == 2'h1
         && ir_shift == IR_CAPTURE)
      else $error("capture-ir pattern wrong");

   ir_update_a: assert property (@(posedge i_test_clock_in)
      disable iff (!i_test_reset_in_n)
      $past(state) == st_update_ir |-> ir == $past(ir_shift))
      else $error("instruction not taken in update-ir");

   reset_idcode_a: assert property (@(posedge i_test_clock_in)
      disable iff (!i_test_reset_in_n)
      $past(state) == st_reset |-> ir == IR_IDCODE)
      else $error("reset did not select idcode");

   id_capture_a: assert property (@(posedge i_test_clock_in)
      disable iff (!i_test_reset_in_n)
      cap_dr && sel == sel_ident |=> id_shift == id_code && id_shift[0])
      else $error("id code not loaded");

   bypass_path_a: assert property (@(posedge i_test_clock_in)
      disable iff (!i_test_reset_in_n)
      sh_dr && sel == sel_bypass |=> bypass == $past(i_test_serial_in))
      else $error("bypass bit did not follow serial in");

   tdo_float_a: assert property (@(posedge i_test_clock_in)
      disable iff (!i_test_reset_in_n)
      $past(state) != st_shift_dr && $past(state) != st_shift_ir
         && state != st_shift_dr && state != st_shift_ir
         |-> o_test_serial_out_oe_n)
      else $error("serial out driven outside shift");

   // checks in the system clock domain
   highz_pins_a: assert property (@(posedge i_clk) disable iff (i_reset)
      sys_ctrl.highz |=> o_pin_oe_n == '1)
      else $error("high-z left a pin driven");

   drive_pins_a: assert property (@(posedge i_clk) disable iff (i_reset)
      sys_ctrl.drive && !sys_ctrl.highz
         |=> o_pin_out == $past(sys_ctrl.cells[OUT_BASE +: NUM_OUT]))
      else $error("test drive did not use latches");

endmodule

// *** bench/scan_tester.sv ***
// Purpose: model of the external boundary-scan tester
// Assumes: 30 ns test clock, run only while a frame is in progress
// Notes: clock rests low between steps; inputs change at the falling edge
`timescale 1ns/1ps
module scan_tester (
   // link toward the test port
   output logic o_tck,
   output logic o_trst_n,
   output logic o_tms,
   output logic o_tdi,
   input wire logic i_tdo,
   input wire logic i_tdo_oe_n
);
   // idle link levels until the first frame
   initial
   begin
      o_tck = 1'b0;
      o_trst_n = 1'b1;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end

   // one test clock: set select and data, sample out before rising edge
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      o_tms = tms;
      o_tdi = tdi;
      #15;
      // a released line reads high through the tester's pull-up
      tdo = i_tdo_oe_n ? 1'b1 : i_tdo;
      o_tck = 1'b1;
      #15;
      o_tck = 1'b0;
   endtask

   // test reset held across one edge so the port sees it for sure
   task automatic pulse_reset();
      logic d;
      o_trst_n = 1'b0;
      step(1'b1, 1'b0, d);
      o_trst_n = 1'b1;
   endtask
endmodule

// *** bench/boundary_scan_tap_tb.sv ***
// Purpose: self-checking bench for the test access port
// Assumes: tester model drives the link; core pins driven from here
// Notes: pin checks wait 20 system clocks for the control word crossing
`timescale 1ns/1ps
module boundary_scan_tap_tb;
   import tap_pkg::*;
   localparam logic [31:0] ID = {4'h1, 16'h1234, 11'h2AA, 1'b1};
   localparam logic [195:0] PRE = 196'h0B41E;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic tck, trst_n, tms, tdi, tdo, tdo_oe_n;
   logic [15:0] core_out = 16'hA5C3;
   logic [15:0] core_oe_n = 16'h00F0;
   logic [15:0] pin_in = 16'h3C96;
   logic [15:0] pin_out, pin_oe_n;
   logic [195:0] dout;
   int failures = 0;
   int compares = 0;
   int cycles = 0;

   boundary_scan_tap #(.ID_MAKER(11'h2AA), .ID_PART(16'h1234),
      .ID_VERSION(4'h1)) u_dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_test_clock_in(tck),
      .i_test_reset_in_n(trst_n), .i_test_mode_select(tms),
      .i_test_serial_in(tdi), .o_test_serial_out(tdo),
      .o_test_serial_out_oe_n(tdo_oe_n), .i_core_out(core_out),
      .i_core_oe_n(core_oe_n), .i_pin_in(pin_in), .o_pin_out(pin_out),
      .o_pin_oe_n(pin_oe_n));

   scan_tester u_tester (.o_tck(tck), .o_trst_n(trst_n), .o_tms(tms),
      .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n));

   always #2 i_clk = ~i_clk;

   // hang guard, far above the roughly 700 test clocks used
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         failures++;
         complete_run();
      end
   end

   task automatic check(input string name, input logic [195:0] seen,
      input logic [195:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one scan from idle back to idle, optional pause after bit pause_at
   task automatic scan(input logic ir, input int n, input int pause_at,
      input logic [195:0] din, output logic [195:0] dq);
      logic d;
      dq = '0;
      u_tester.step(1'b1, 1'b0, d);
      if (ir)
         u_tester.step(1'b1, 1'b0, d);
      u_tester.step(1'b0, 1'b0, d);
      u_tester.step(1'b0, 1'b0, d);
      for (int i = 0; i < n; i++)
      begin
         if (i == 1)
         begin
            // let the falling-edge update settle before looking
            #1;
            check("out enable in shift", 196'(tdo_oe_n), 196'h0);
         end
         u_tester.step(i == n - 1 || i == pause_at, din[i], dq[i]);
         if (i == pause_at)
         begin
            u_tester.step(1'b0, 1'b0, d);
            u_tester.step(1'b0, 1'b0, d);
            #1;
            check("out enable in pause", 196'(tdo_oe_n), 196'h1);
            u_tester.step(1'b1, 1'b0, d);
            u_tester.step(1'b0, 1'b0, d);
         end
      end
      u_tester.step(1'b1, 1'b0, d);
      u_tester.step(1'b0, 1'b0, d);
   endtask

   // instruction load with a pause after bit 1, checking the capture value
   task automatic load_ir(input logic [2:0] code);
      scan(1'b1, 3, 1, 196'(code), dout);
      check("ir capture", dout[2:0], 196'(IR_CAPTURE));
      check("ir capture low bits", dout[1:0], 196'h1);
   endtask

   task automatic check_pins(input logic [15:0] out, input logic [15:0] oe);
      repeat (20) @(negedge i_clk);
      check("pin out", pin_out, 196'(out));
      check("pin enable", pin_oe_n, 196'(oe));
   endtask

   // id read after test reset, with a pause in mid-shift
   task automatic test_idcode();
      u_tester.pulse_reset();
      u_tester.step(1'b0, 1'b0, dout[0]);
      scan(1'b0, 32, 15, '0, dout);
      check("id code", dout[31:0], 196'(ID));
      check_pins(core_out, core_oe_n);
   endtask

   // one-bit path for bypass, clamp, high-z and the unused codes
   task automatic test_bypass();
      logic [2:0] codes [5] = '{IR_BYPASS, IR_CLAMP, IR_HIGHZ, 3'h5, 3'h6};
      foreach (codes[k])
      begin
         load_ir(codes[k]);
         scan(1'b0, 9, -1, 196'h0B5, dout);
         check("bypass path", dout[8:0], 196'h16A);
      end
   endtask

   // sample, preload, then drive pins from the latches
   task automatic test_boundary();
      load_ir(IR_SAMPLE);
      scan(1'b0, 196, -1, PRE, dout);
      check("sample capture", dout, {pin_in, core_out, core_oe_n[0]});
      check_pins(core_out, core_oe_n);
      load_ir(IR_EXTEST);
      check_pins(16'h5A0F, 16'h0000);
      scan(1'b0, 196, -1, PRE, dout);
      check("extest capture", dout, {pin_in, 16'h5A0F, 1'b0});
      @(negedge i_clk);
      core_out = 16'h0FF0;
      load_ir(IR_CLAMP);
      check_pins(16'h5A0F, 16'h0000);
      load_ir(IR_HIGHZ);
      check_pins(core_out, 16'hFFFF);
      load_ir(IR_BYPASS);
      check_pins(core_out, core_oe_n);
   endtask

   // five high selects from shift-dr reach reset without the reset pin
   task automatic test_tms_reset();
      logic d;
      u_tester.step(1'b1, 1'b0, d);
      u_tester.step(1'b0, 1'b0, d);
      u_tester.step(1'b0, 1'b0, d);
      repeat (TMS_RESET_EDGES) u_tester.step(1'b1, 1'b0, d);
      u_tester.step(1'b0, 1'b0, d);
      scan(1'b0, 32, -1, '0, dout);
      check("id after select reset", dout[31:0], 196'(ID));
   endtask

   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge i_clk);
      @(negedge i_clk);
      i_reset = 1'b0;
      #7;
      test_idcode();
      test_bypass();
      test_boundary();
      test_tms_reset();
      complete_run();
   end
endmodule
